// file: sim/conv_model.sv
// Behavioural converter, sense ADC and regulation flag model
`timescale 1ns/10ps
module conv_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [9:0] v_set_i,
   input wire logic [9:0] i_set_i,
   input wire logic cv_i,
   output logic sample_valid_o,
   output logic [9:0] v_sample_o,
   output logic [9:0] i_sample_o,
   output logic cur_reg_o
);
   // Strobe every other cycle; lines carry inverted junk between strobes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sample_valid_o <= 1'b0;
         v_sample_o <= 10'h000;
         i_sample_o <= 10'h000;
      end else begin
         sample_valid_o <= !sample_valid_o;
         v_sample_o <= sample_valid_o ? ~v_set_i : v_set_i;
         i_sample_o <= sample_valid_o ? ~i_set_i : i_set_i;
      end
   end

   // Current regulation flag, low in constant-voltage mode
   assign cur_reg_o = !cv_i;
endmodule

// file: sim/li_ion_charge_state_machine_tb.sv
// Self-checking bench for the charge controller
`timescale 1ns/10ps
module li_ion_charge_state_machine_tb;
   import charger_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, btn = 1'b0, cv = 1'b0, l;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dw = 32'h0, dr, rd;
   logic [9:0] vset = 10'h000, iset = 10'h000, vs, is;
   logic ack, sv, cr, conv, led;
   logic [11:0] vref, iref;
   int error_cnt = 0, n_tests = 0, cyc_cnt = 0;

   // 40 MHz clock
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   charge_controller #(.QUARTER_CYCLES(4)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
      .sample_valid_i(sv), .v_sample_i(vs), .i_sample_i(is), .cur_reg_i(cr),
      .button_i(btn), .vref_o(vref), .iref_o(iref), .conv_en_o(conv), .led_o(led)
   );

   conv_model i_model (
      .clk_i(clk_i), .rst_i(rst_i), .v_set_i(vset), .i_set_i(iset), .cv_i(cv),
      .sample_valid_o(sv), .v_sample_o(vs), .i_sample_o(is), .cur_reg_o(cr)
   );

   task automatic end_sim;
      $display("errors=%0d compares=%0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      dw <= d;
      // Wait for ack has no limit of its own; only the hang guard bounds it
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // Poll status until the state code shows up, bounded
   task automatic chk_state(input logic [2:0] c);
      int n;
      n = 0;
      do wb(1'b0, ADR_STATUS, 32'h0); while (rd[2:0] !== c && ++n < 100);
      chk(32'(rd[2:0]), 32'(c));
   endtask

   // Button held long enough to pass the synchroniser
   task automatic press;
      @(posedge clk_i);
      btn <= 1'b1;
      repeat (6) @(posedge clk_i);
      btn <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask

   // Hang guard
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         end_sim();
      end
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(32'({led, conv, vref, iref}), 32'h0);
      chk_reg(ADR_STATUS, 32'h0);
      chk_reg(ADR_CTRL, 32'h0);
      chk_reg(ADR_VTHR, 32'h0cc00b00);
      chk_reg(ADR_ILIM, 32'h07d000c8);
      chk_reg(ADR_TERM, 32'h003c0064);
      chk_reg(ADR_TIMEOUT, 32'h00003840);
      chk_reg(8'h40, 32'h0);
      wb(1'b1, ADR_STATUS, 32'hffffffff);
      chk_reg(ADR_STATUS, 32'h0);
      // Measurement sums four samples; voltage right at cutoff
      vset <= 10'h2c0;
      iset <= 10'h019;
      repeat (20) @(posedge clk_i);
      chk_reg(ADR_MEAS, 32'h00640b00);
      press();
      chk(32'(conv), 32'h1);
      chk(32'(vref), 32'(V_CHARGE));
      chk(32'(iref), 32'(I_PRE_RST));
      chk_state(CODE_PRE);
      l = led;
      repeat (16) @(posedge clk_i);
      chk(32'(led), {31'h0, ~l});
      repeat (40) @(posedge clk_i);
      chk_state(CODE_PRE);
      vset <= 10'h2c1;
      chk_state(CODE_CHARGE);
      chk(32'(iref), 32'(I_CHARGE_RST));
      // Low current in constant-current mode must not terminate
      iset <= 10'h010;
      repeat (64) @(posedge clk_i);
      chk_state(CODE_CHARGE);
      cv <= 1'b1;
      chk_state(CODE_DONE);
      chk(32'({conv, vref, iref}), 32'h0);
      chk(32'(led), 32'h1);
      chk_state(CODE_IDLE);
      // Battery removed during charge
      iset <= 10'h040;
      press();
      chk_state(CODE_CHARGE);
      iset <= 10'h003;
      chk_state(CODE_IDLE);
      chk(32'(conv), 32'h0);
      // No battery in precharge: present first, then current drops away
      vset <= 10'h100;
      iset <= 10'h040;
      repeat (20) @(posedge clk_i);
      press();
      chk_state(CODE_PRE);
      iset <= 10'h003;
      chk_state(CODE_IDLE);
      // Flat current ends charge, standby then recharges
      wb(1'b1, ADR_CTRL, 32'h1);
      wb(1'b1, ADR_TERM, 32'h00020000);
      vset <= 10'h340;
      iset <= 10'h040;
      repeat (20) @(posedge clk_i);
      press();
      chk_state(CODE_CHARGE);
      chk_state(CODE_DONE);
      repeat (40) @(posedge clk_i);
      chk_state(CODE_DONE);
      vset <= 10'h300;
      chk_state(CODE_CHARGE);
      press();
      chk(32'(conv), 32'h0);
      chk_state(CODE_IDLE);
      // Timeout in constant-current charge
      wb(1'b1, ADR_TIMEOUT, 32'h3);
      cv <= 1'b0;
      press();
      chk_state(CODE_CHARGE);
      chk_state(CODE_FAULT);
      chk(32'(conv), 32'h0);
      l = led;
      repeat (4) @(posedge clk_i);
      chk(32'(led), {31'h0, ~l});
      press();
      chk_state(CODE_IDLE);
      chk(32'(led), 32'h0);
      end_sim();
   end
endmodule

// file: verilog/charge_controller.sv
// Once-per-second single-cell charge state machine with Wishbone registers
// Contract
// - Evaluate state once per second, measurements only
// - Each evaluation sets voltage and current targets
// - Values are 12 bits, four 10-bit samples
// - Termination only in constant-voltage regulation
// - Below 16 counts means no battery
// - Precharge low current until voltage passes cutoff
// - Charge: constant current then hold 4.2 V
// - Minimum or flat current ends charge
// - Battery lost during charge goes idle
// - Timeout during charge goes to fault
// - Done stops converter, optional standby recharge
// - Without standby, done goes idle
// - Idle: converter off, press restarts charging
// - Fault: converter off, press goes idle
// - LED off, slow blink, on, fast blink
// - One button toggles charging on and off
// - Default limits 1000 mA and 4.2 V
// - State codes idle0 fault1 done2 pre3 charge4 float5
// - Start loads counters and limits, then runs
// - Flat counter reloads on minimum update, ends
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module charge_controller #(
   parameter int QUARTER_CYCLES = charger_pkg::QUARTER_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sample_valid_i,
   input wire logic [charger_pkg::SAMPLE_W-1:0] v_sample_i,
   input wire logic [charger_pkg::SAMPLE_W-1:0] i_sample_i,
   input wire logic cur_reg_i,
   input wire logic button_i,
   output logic [charger_pkg::MEAS_W-1:0] vref_o,
   output logic [charger_pkg::MEAS_W-1:0] iref_o,
   output logic conv_en_o,
   output logic led_o
);
   import charger_pkg::*;

   charge_state_e state;
   charge_state_e next_state;
   logic [MEAS_W-1:0] v_meas;
   logic [MEAS_W-1:0] i_meas;
   logic [2:0] btn_sync;
   logic [1:0] cr_sync;
   logic press;
   logic cv;
   logic [23:0] qcnt;
   logic [1:0] quarter;
   logic q_tick;
   logic sec_tick;
   logic [15:0] tmo;
   logic [11:0] imin;
   logic [1:0] imin_db;
   logic [7:0] flat;
   logic standby_en;
   logic [11:0] v_cutoff;
   logic [11:0] v_recharge;
   logic [11:0] i_pre;
   logic [11:0] i_chg;
   logic [11:0] i_min_thr;
   logic [7:0] flat_sec;
   logic [15:0] timeout_sec;
   logic [31:0] wr_word;
   logic bus_req;

   // Status code of a state
   function automatic logic [2:0] state_code(input charge_state_e s);
      case (s)
         ST_IDLE: state_code = CODE_IDLE;
         ST_FAULT: state_code = CODE_FAULT;
         ST_DONE: state_code = CODE_DONE;
         ST_PRE: state_code = CODE_PRE;
         ST_CHARGE: state_code = CODE_CHARGE;
         default: state_code = CODE_FLOAT;
      endcase
   endfunction

   // Readback word of a register offset
   function automatic logic [31:0] reg_word(input logic [7:0] adr);
      case (adr)
         ADR_CTRL: reg_word = {31'h0, standby_en};
         ADR_STATUS: reg_word = {26'h0, led_o, conv_en_o, cv, state_code(state)};
         ADR_MEAS: reg_word = {4'h0, i_meas, 4'h0, v_meas};
         ADR_VTHR: reg_word = {4'h0, v_recharge, 4'h0, v_cutoff};
         ADR_ILIM: reg_word = {4'h0, i_chg, 4'h0, i_pre};
         ADR_TERM: reg_word = {8'h0, flat_sec, 4'h0, i_min_thr};
         ADR_TIMEOUT: reg_word = {16'h0, timeout_sec};
         default: reg_word = 32'h0;
      endcase
   endfunction

   // Voltage and current measurement accumulators
   sample_accum v_acc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .valid_i(sample_valid_i),
      .sample_i(v_sample_i),
      .sum_o(v_meas)
   );
   sample_accum i_acc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .valid_i(sample_valid_i),
      .sample_i(i_sample_i),
      .sum_o(i_meas)
   );

   // Pin synchronisers for button and regulation flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         btn_sync <= 3'h0;
         cr_sync <= 2'h0;
      end else begin
         btn_sync <= {btn_sync[1:0], button_i};
         cr_sync <= {cr_sync[0], cur_reg_i};
      end
   end
   assign press = btn_sync[1] & ~btn_sync[2];
   assign cv = ~cr_sync[1];

   // Quarter-second and one-second time base
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         qcnt <= 24'h0;
         quarter <= 2'h0;
      end else if (q_tick) begin
         qcnt <= 24'h0;
         quarter <= quarter + 2'h1;
      end else begin
         qcnt <= qcnt + 24'h1;
      end
   end
   assign q_tick = (qcnt == 24'(QUARTER_CYCLES - 1));
   assign sec_tick = q_tick && (quarter == QUARTERS_LAST);

   // Next state: button first, then the once-per-second evaluation
   always_comb begin
      next_state = state;
      if (press) begin
         next_state = (state == ST_IDLE) ? ST_PRE : ST_IDLE;
      end else if (sec_tick) begin
         case (state)
            ST_PRE: begin
               if (i_meas < I_BAT_DETECT) begin
                  next_state = ST_IDLE;
               end else if (v_meas > v_cutoff) begin
                  next_state = ST_CHARGE;
               end else if (tmo == 16'h0) begin
                  next_state = ST_FAULT;
               end
            end
            ST_CHARGE: begin
               if (i_meas < I_BAT_DETECT) begin
                  next_state = ST_IDLE;
               end else if (cv && (i_meas < i_min_thr || flat == 8'h0)) begin
                  next_state = ST_DONE;
               end else if (tmo == 16'h0) begin
                  next_state = ST_FAULT;
               end
            end
            ST_DONE: begin
               if (!standby_en) begin
                  next_state = ST_IDLE;
               end else if (v_meas < v_recharge) begin
                  next_state = ST_CHARGE;
               end
            end
            default: next_state = state;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // State timeout, reloaded on every state entry
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tmo <= 16'h0;
      end else if (state != next_state) begin
         tmo <= timeout_sec;
      end else if (sec_tick && tmo != 16'h0 && (state == ST_PRE || state == ST_CHARGE)) begin
         tmo <= tmo - 16'h1;
      end
   end

   // Minimum current tracking and flat current counter
   always_ff @(posedge clk_i) begin
      if (rst_i || state != next_state) begin
         imin <= I_MIN_START;
         imin_db <= IMIN_UPDATE;
         flat <= flat_sec;
      end else if (sec_tick && state == ST_CHARGE && cv) begin
         if (i_meas < imin && imin_db == 2'h1) begin
            imin <= i_meas;
            imin_db <= IMIN_UPDATE;
            flat <= flat_sec;
         end else begin
            imin_db <= (i_meas < imin) ? imin_db - 2'h1 : IMIN_UPDATE;
            flat <= (flat != 8'h0) ? flat - 8'h1 : flat;
         end
      end
   end

   // Converter enable and targets, set at start and each evaluation
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_en_o <= 1'b0;
         vref_o <= '0;
         iref_o <= '0;
      end else if (press || sec_tick) begin
         conv_en_o <= (next_state == ST_PRE || next_state == ST_CHARGE);
         vref_o <= (next_state == ST_PRE || next_state == ST_CHARGE) ? V_CHARGE : 12'h0;
         iref_o <= (next_state == ST_PRE) ? i_pre : (next_state == ST_CHARGE) ? i_chg : 12'h0;
      end
   end

   // Status LED pattern
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         led_o <= 1'b0;
      end else begin
         case (state)
            ST_DONE: led_o <= 1'b1;
            ST_FAULT: led_o <= q_tick ? ~led_o : led_o;
            ST_PRE, ST_CHARGE: led_o <= sec_tick ? ~led_o : led_o;
            default: led_o <= 1'b0;
         endcase
      end
   end

   // Wishbone slave: ack one cycle after request, write at the acked edge
   assign bus_req = wb_cyc_i && wb_stb_i;
   always_comb begin
      wr_word = reg_word(wb_adr_i);
      for (int b = 0; b < 4; b++) begin
         if (wb_sel_i[b]) begin
            wr_word[b*8 +: 8] = wb_dat_i[b*8 +: 8];
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= bus_req && !wb_ack_o;
         wb_dat_o <= (bus_req && !wb_ack_o && !wb_we_i) ? reg_word(wb_adr_i) : 32'h0;
      end
   end

   // Configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         standby_en <= 1'b0;
         v_cutoff <= V_CUTOFF_RST;
         v_recharge <= V_RECHARGE_RST;
         i_pre <= I_PRE_RST;
         i_chg <= I_CHARGE_RST;
         i_min_thr <= I_MIN_RST;
         flat_sec <= FLAT_SEC_RST;
         timeout_sec <= TIMEOUT_SEC_RST;
      end else if (bus_req && wb_ack_o && wb_we_i) begin
         case (wb_adr_i)
            ADR_CTRL: standby_en <= wr_word[0];
            ADR_VTHR: begin
               v_cutoff <= wr_word[LO_FIELD +: 12];
               v_recharge <= wr_word[HI_FIELD +: 12];
            end
            ADR_ILIM: begin
               i_pre <= wr_word[LO_FIELD +: 12];
               i_chg <= wr_word[HI_FIELD +: 12];
            end
            ADR_TERM: begin
               i_min_thr <= wr_word[LO_FIELD +: 12];
               flat_sec <= wr_word[HI_FIELD +: 8];
            end
            ADR_TIMEOUT: timeout_sec <= wr_word[15:0];
            default: standby_en <= standby_en;
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence idle_press;
      state == ST_IDLE && press;
   endsequence
   sequence pre_running;
      state == ST_PRE && conv_en_o && iref_o == i_pre && vref_o == V_CHARGE;
   endsequence

   state_eval_a: assert property (state != $past(state) |-> $past(sec_tick || press))
      else $error("state changed outside evaluation or press");
   start_run_a: assert property (idle_press |=> pre_running)
      else $error("press in idle did not start precharge");
   charge_target_a: assert property (sec_tick && state == ST_PRE && next_state == ST_CHARGE
      |=> conv_en_o && vref_o == V_CHARGE && iref_o == i_chg)
      else $error("charge targets not loaded");
   cv_gate_a: assert property (state == ST_CHARGE && next_state == ST_DONE |-> cv)
      else $error("termination outside constant voltage");
   batt_lost_a: assert property (sec_tick && !press && state == ST_CHARGE && i_meas < I_BAT_DETECT
      |=> state == ST_IDLE && !conv_en_o)
      else $error("missing battery not detected");
   flat_end_a: assert property (sec_tick && !press && state == ST_CHARGE && cv && flat == 8'h0
      && i_meas >= I_BAT_DETECT |=> state == ST_DONE)
      else $error("flat current did not end charge");
   timeout_a: assert property (sec_tick && !press && state == ST_CHARGE && tmo == 16'h0
      && i_meas >= I_BAT_DETECT && !cv |=> state == ST_FAULT)
      else $error("timeout did not fault");
   off_states_a: assert property (state inside {ST_IDLE, ST_FAULT, ST_DONE}
      && $past(state) == state |-> !conv_en_o)
      else $error("converter running in stopped state");
   fault_press_a: assert property (state == ST_FAULT && press |=> state == ST_IDLE)
      else $error("press did not leave fault");
   led_steady_a: assert property (state == ST_DONE ##1 state == ST_DONE |-> led_o)
      else $error("led not on in done");
   bus_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held over two cycles");
endmodule

// file: verilog/charger_pkg.sv
// Constants, register map and state codes of the charge controller
package charger_pkg;
   // Clock and time base
   localparam int CLK_HZ = 40_000_000;
   localparam int QUARTER_MS = 250;
   localparam int QUARTER_CYCLES = CLK_HZ / 1000 * QUARTER_MS;
   localparam logic [1:0] QUARTERS_LAST = 2'h3;

   // Measurement widths
   localparam int SAMPLE_W = 10;
   localparam int MEAS_W = 12;
   localparam logic [1:0] SAMPLES_LAST = 2'h3;

   // Thresholds and targets in 12-bit counts; flat time and timeout in seconds, minimum-update debounce count
   localparam logic [11:0] I_BAT_DETECT = 12'h010;
   localparam logic [11:0] V_CHARGE = 12'hd73;
   localparam logic [11:0] I_CHARGE_RST = 12'h7d0;
   localparam logic [11:0] I_PRE_RST = 12'h0c8;
   localparam logic [11:0] V_CUTOFF_RST = 12'hb00;
   localparam logic [11:0] V_RECHARGE_RST = 12'hcc0;
   localparam logic [11:0] I_MIN_RST = 12'h064;
   localparam logic [11:0] I_MIN_START = 12'hfff;
   localparam logic [7:0] FLAT_SEC_RST = 8'h3c;
   localparam logic [15:0] TIMEOUT_SEC_RST = 16'h3840;
   localparam logic [1:0] IMIN_UPDATE = 2'h3;

   // Register byte offsets
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_MEAS = 8'h08;
   localparam logic [7:0] ADR_VTHR = 8'h0c;
   localparam logic [7:0] ADR_ILIM = 8'h10;
   localparam logic [7:0] ADR_TERM = 8'h14;
   localparam logic [7:0] ADR_TIMEOUT = 8'h18;

   // Field positions
   localparam int LO_FIELD = 0;
   localparam int HI_FIELD = 16;
   localparam int ST_CV_BIT = 3;
   localparam int ST_CONV_BIT = 4;
   localparam int ST_LED_BIT = 5;

   // Charging state codes as reported in the status register
   localparam logic [2:0] CODE_IDLE = 3'h0;
   localparam logic [2:0] CODE_FAULT = 3'h1;
   localparam logic [2:0] CODE_DONE = 3'h2;
   localparam logic [2:0] CODE_PRE = 3'h3;
   localparam logic [2:0] CODE_CHARGE = 3'h4;
   localparam logic [2:0] CODE_FLOAT = 3'h5;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_FAULT = 5'h02,
      ST_DONE = 5'h04,
      ST_PRE = 5'h08,
      ST_CHARGE = 5'h10
   } charge_state_e;
endpackage

// file: verilog/sample_accum.sv
// Sums four consecutive 10-bit samples into one 12-bit measurement
`timescale 1ns/10ps
module sample_accum (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic valid_i,
   input wire logic [charger_pkg::SAMPLE_W-1:0] sample_i,
   output logic [charger_pkg::MEAS_W-1:0] sum_o
);
   import charger_pkg::*;

   logic [1:0] count;
   logic [MEAS_W-1:0] acc;
   logic [MEAS_W-1:0] next_acc;

   // Running sum including the current sample
   assign next_acc = acc + {2'h0, sample_i};

   // Fourth sample closes the measurement
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= 2'h0;
         acc <= '0;
         sum_o <= '0;
      end else if (valid_i) begin
         count <= count + 2'h1;
         if (count == SAMPLES_LAST) begin
            sum_o <= next_acc;
            acc <= '0;
         end else begin
            acc <= next_acc;
         end
      end
   end
endmodule
